// *** hdl/mmbd_pkg.sv ***
// Constants and carrier types for the memory map and bank decoder.
package mmbd_pkg;

    localparam int          PC_W          = 13;
    localparam int          PM_AW         = 11;
    localparam int          INSN_W        = 14;
    localparam int          DA_W          = 9;
    localparam int          OFS_W         = 7;
    localparam int          GPR_W         = 7;
    localparam logic [12:0] RESET_VECTOR  = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR    = 13'h0004;
    localparam logic [6:0]  OFS_INDIRECT  = 7'h00;
    localparam logic [6:0]  OFS_PC_LOW    = 7'h02;
    localparam logic [6:0]  OFS_STATUS    = 7'h03;
    localparam logic [6:0]  OFS_POINTER   = 7'h04;
    localparam logic [6:0]  OFS_PORT_FOUR = 7'h08;
    localparam logic [6:0]  OFS_PORT_FIVE = 7'h09;
    localparam logic [6:0]  OFS_PCLATCH   = 7'h0a;
    localparam logic [6:0]  OFS_INTCTL    = 7'h0b;
    localparam logic [6:0]  OFS_GPR_LO    = 7'h20;
    localparam logic [6:0]  OFS_GPR_B1_HI = 7'h3f;
    localparam logic [6:0]  OFS_SHARED    = 7'h70;
    localparam logic [8:0]  ADDR_RSV_A    = 9'h18e;
    localparam logic [8:0]  ADDR_RSV_B    = 9'h18f;
    localparam logic [6:0]  B1_GPR_BASE   = 7'h00;
    localparam int          STATUS_SEL_LO = 5;
    localparam int          STATUS_SEL_HI = 6;
    localparam int          STATUS_IRP    = 7;
    localparam logic [7:0]  STATUS_RESET  = 8'h18;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    localparam logic [4:0]  PCLATCH_RESET = 5'h00;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       ind;
        logic [6:0] ofs;
        logic [7:0] wdata;
    } mmbd_dreq_t;

    typedef enum logic [2:0] {
        MMBD_T_NONE,
        MMBD_T_GPR,
        MMBD_T_STATUS,
        MMBD_T_POINTER,
        MMBD_T_PC_LOW,
        MMBD_T_PCLATCH,
        MMBD_T_INTCTL,
        MMBD_T_PORT
    } mmbd_target_t;

endpackage

// *** hdl/mmbd_gpr_ram.sv ***
// General purpose static RAM array behind the data bus.
`timescale 1ns/1ps
module mmbd_gpr_ram
    import mmbd_pkg::*;
#(
    parameter int DEPTH = 128
)
(
    input  wire logic                ref_clk_i,
    input  wire logic                we_i,
    input  wire logic [GPR_W-1:0]    waddr_i,
    input  wire logic [7:0]          wdata_i,
    input  wire logic [GPR_W-1:0]    raddr_i,
    output logic      [7:0]          rdata_o
);
    logic [7:0] mem [DEPTH];

    // Storage holds no reset; its contents are unknown after power-up.
    always_ff @(posedge ref_clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_comb
    begin
        rdata_o = mem[raddr_i];
    end
endmodule // mmbd_gpr_ram

// *** hdl/mmbd_decoder.sv ***
// Program counter, bank select and data memory decoder of the core.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module mmbd_decoder
    import mmbd_pkg::*;
#(
    parameter bit HAS_PORTS_DE = 1'b1
)
(
    input  wire logic                     ref_clk_i,
    input  wire logic                     reset_i,
    input  wire logic                     pc_step_i,
    input  wire logic                     pc_load_i,
    input  wire logic [10:0]              pc_target_i,
    input  wire logic                     irq_accept_i,
    output logic      [PC_W-1:0]          pc_o,
    output logic      [PM_AW-1:0]         pm_addr_o,
    input  wire mmbd_pkg::mmbd_dreq_t     dreq_i,
    output logic      [7:0]               rdata_o,
    output logic      [DA_W-1:0]          dm_addr_o,
    output logic                          unimpl_o,
    output logic      [7:0]               status_o,
    output logic      [7:0]               pointer_o,
    output logic      [7:0]               intctl_o,
    output logic                          port_we_o,
    output logic      [7:0]               port_wdata_o,
    input  wire logic [7:0]               port_rdata_i
);
    import mmbd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Program counter.

    logic [PC_W-1:0]  pc;
    logic [PC_W-1:0]  next_pc;
    logic [4:0]       pclatch;
    logic [4:0]       next_pclatch;
    logic [PM_AW-1:0] pm_addr;
    logic [PM_AW-1:0] next_pm_addr;

    always_comb
    begin
        next_pc = pc;
        if (irq_accept_i)
        begin
            next_pc = IRQ_VECTOR;
        end
        else if (pc_load_i)
        begin
            next_pc = {pclatch[4:3], pc_target_i};
        end
        else if (pc_step_i)
        begin
            next_pc = pc + 13'h0001;
        end
        // Dropping the upper bits makes high addresses alias low words.
        next_pm_addr = next_pc[PM_AW-1:0];
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pc      <= RESET_VECTOR;
            pm_addr <= RESET_VECTOR[PM_AW-1:0];
        end
        else
        begin
            pc      <= next_pc;
            pm_addr <= next_pm_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data address formation.

    logic [7:0]      status;
    logic [7:0]      pointer;
    logic [7:0]      intctl;
    logic [1:0]      bank;
    logic [OFS_W-1:0] ofs;
    logic [DA_W-1:0] daddr;
    mmbd_target_t    target;
    logic [GPR_W-1:0] gpr_idx;

    always_comb
    begin
        // Offset zero is not storage: it always follows the pointer.
        if (dreq_i.ind || dreq_i.ofs == OFS_INDIRECT)
        begin
            bank = {status[STATUS_IRP], pointer[7]};
            ofs  = pointer[6:0];
        end
        else
        begin
            bank = {status[STATUS_SEL_HI], status[STATUS_SEL_LO]};
            ofs  = dreq_i.ofs;
        end
        daddr = {bank, ofs};
    end

    always_comb
    begin
        target  = MMBD_T_NONE;
        gpr_idx = ofs;
        // A pointer aimed at offset zero reads as unimplemented.
        if (ofs == OFS_INDIRECT)
        begin
            target = MMBD_T_NONE;
        end
        else if (ofs == OFS_STATUS)
        begin
            target = MMBD_T_STATUS;
        end
        else if (ofs == OFS_POINTER)
        begin
            target = MMBD_T_POINTER;
        end
        else if (ofs == OFS_PC_LOW)
        begin
            target = MMBD_T_PC_LOW;
        end
        else if (ofs == OFS_PCLATCH)
        begin
            target = MMBD_T_PCLATCH;
        end
        else if (ofs == OFS_INTCTL)
        begin
            target = MMBD_T_INTCTL;
        end
        else if ((ofs == OFS_PORT_FOUR || ofs == OFS_PORT_FIVE) && !bank[1])
        begin
            target = HAS_PORTS_DE ? MMBD_T_PORT : MMBD_T_NONE;
        end
        else if (ofs >= OFS_SHARED)
        begin
            target = MMBD_T_GPR;
        end
        else if (ofs >= OFS_GPR_LO && !bank[0])
        begin
            target = MMBD_T_GPR;
        end
        else if (ofs >= OFS_GPR_LO && ofs <= OFS_GPR_B1_HI)
        begin
            // Bank 1 RAM takes the slots below 20h that bank 0 leaves
            // free, so the two banks overlap only in the shared 70h-7Fh slots.
            target  = MMBD_T_GPR;
            gpr_idx = B1_GPR_BASE + (ofs - OFS_GPR_LO);
        end
        else
        begin
            target = MMBD_T_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register file and RAM.

    logic [7:0] ram_rdata;
    logic       ram_we;
    logic [7:0] next_status;
    logic [7:0] next_pointer;
    logic [7:0] next_intctl;
    logic [7:0] next_rdata;
    logic [7:0] rdata;
    logic       next_unimpl;
    logic       unimpl;
    logic       port_we;
    logic       next_port_we;
    logic [7:0] port_wdata;
    logic [DA_W-1:0] dm_addr;

    mmbd_gpr_ram #(
        .DEPTH (128)
    ) u_ram (
        .ref_clk_i (ref_clk_i),
        .we_i      (ram_we),
        .waddr_i   (gpr_idx),
        .wdata_i   (dreq_i.wdata),
        .raddr_i   (gpr_idx),
        .rdata_o   (ram_rdata)
    );

    always_comb
    begin
        ram_we       = dreq_i.wr && target == MMBD_T_GPR;
        next_status  = status;
        next_pointer = pointer;
        next_intctl  = intctl;
        next_pclatch = pclatch;
        next_port_we = dreq_i.wr && target == MMBD_T_PORT;
        next_unimpl  = (dreq_i.wr || dreq_i.rd) && target == MMBD_T_NONE;
        next_rdata   = ZERO_BYTE;
        if (dreq_i.wr)
        begin
            case (target)
                MMBD_T_STATUS:  next_status  = dreq_i.wdata;
                MMBD_T_POINTER: next_pointer = dreq_i.wdata;
                MMBD_T_INTCTL:  next_intctl  = dreq_i.wdata;
                MMBD_T_PCLATCH: next_pclatch = dreq_i.wdata[4:0];
                default:        next_pclatch = pclatch;
            endcase
        end
        if (dreq_i.rd)
        begin
            case (target)
                MMBD_T_GPR:     next_rdata = ram_rdata;
                MMBD_T_STATUS:  next_rdata = status;
                MMBD_T_POINTER: next_rdata = pointer;
                MMBD_T_INTCTL:  next_rdata = intctl;
                MMBD_T_PC_LOW:  next_rdata = pc[7:0];
                MMBD_T_PCLATCH: next_rdata = {3'h0, pclatch};
                MMBD_T_PORT:    next_rdata = port_rdata_i;
                default:        next_rdata = ZERO_BYTE;
            endcase
        end
    end

    // Data bus state runs beside the fetch path in the same cycle.
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            status     <= STATUS_RESET;
            pointer    <= ZERO_BYTE;
            intctl     <= ZERO_BYTE;
            pclatch    <= PCLATCH_RESET;
            rdata      <= ZERO_BYTE;
            unimpl     <= 1'b0;
            port_we    <= 1'b0;
            port_wdata <= ZERO_BYTE;
            dm_addr    <= 9'h000;
        end
        else
        begin
            status     <= next_status;
            pointer    <= next_pointer;
            intctl     <= next_intctl;
            pclatch    <= next_pclatch;
            rdata      <= next_rdata;
            unimpl     <= next_unimpl;
            port_we    <= next_port_we;
            port_wdata <= dreq_i.wdata;
            dm_addr    <= daddr;
        end
    end

    assign pc_o         = pc;
    assign pm_addr_o    = pm_addr;
    assign rdata_o      = rdata;
    assign dm_addr_o    = dm_addr;
    assign unimpl_o     = unimpl;
    assign status_o     = status;
    assign pointer_o    = pointer;
    assign intctl_o     = intctl;
    assign port_we_o    = port_we;
    assign port_wdata_o = port_wdata;

    ////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_irq;
        irq_accept_i;
    endsequence

    AST_RESET_PC: assert property (@(posedge ref_clk_i)
        $fell(reset_i) |-> pc == RESET_VECTOR)
        else $error("pc not zero after reset");

    AST_IRQ_VECTOR: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) s_irq |=> pc == IRQ_VECTOR && pm_addr == 11'h004)
        else $error("interrupt vector not taken");

    AST_WRAP: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) pm_addr == pc[PM_AW-1:0])
        else $error("fetch address does not wrap");

    AST_STEP: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) pc_step_i && !pc_load_i && !irq_accept_i
        |=> pc == $past(pc) + 13'h0001)
        else $error("pc did not step");

    AST_BANK: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) (dreq_i.rd || dreq_i.wr) && !dreq_i.ind
        && dreq_i.ofs != OFS_INDIRECT
        |=> dm_addr[8:7] == $past(status[6:5]))
        else $error("bank select wrong");

    AST_INDIRECT: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) (dreq_i.rd || dreq_i.wr)
        && dreq_i.ofs == OFS_INDIRECT
        |=> dm_addr[6:0] == $past(pointer[6:0]))
        else $error("offset zero not redirected");

    AST_UNIMPL_ZERO: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) unimpl |-> rdata == ZERO_BYTE)
        else $error("unimplemented read not zero");

    AST_MIRROR: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) dreq_i.wr && !dreq_i.ind
        && dreq_i.ofs == OFS_POINTER |=> pointer == $past(dreq_i.wdata))
        else $error("mirrored pointer write lost");

    AST_GAP: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) dreq_i.rd && !dreq_i.ind
        && dreq_i.ofs == 7'h40 && status[6:5] == 2'b01 |=> unimpl)
        else $error("bank 1 gap not unimplemented");

    // Bank 1 bytes below the shared slots must never land on a slot that bank 0 RAM owns.
    sequence s_bank1_ram;
        target == MMBD_T_GPR && bank[0] && ofs < OFS_SHARED;
    endsequence

    AST_BANK1_APART: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) s_bank1_ram |-> gpr_idx < OFS_GPR_LO)
        else $error("bank 1 RAM overlaps bank 0 RAM");

    sequence s_port_access;
        (dreq_i.wr || dreq_i.rd) && !dreq_i.ind
        && (dreq_i.ofs == OFS_PORT_FOUR || dreq_i.ofs == OFS_PORT_FIVE);
    endsequence

    AST_SMALL_PORTS: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) s_port_access && !HAS_PORTS_DE
        |=> unimpl && !port_we)
        else $error("small variant reached a port register");
endmodule // mmbd_decoder

// *** testbench/mmbd_port_model.sv ***
// Behavioural stand-in for the fourth and fifth port registers.
`timescale 1ns/1ps
module mmbd_port_model
    import mmbd_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o
);
    import mmbd_pkg::*;

    logic [7:0] latch;
    logic [7:0] next_latch;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_latch = we_i ? wdata_i : latch;
    end

    // Unwritten pins read back as all ones, so a decoder that ignores this
    // input or forces zero cannot pass a port read by luck.
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            latch <= 8'hff;
        else
            latch <= next_latch;
    end

    assign rdata_o = latch;
endmodule // mmbd_port_model

// *** testbench/mmbd_decoder_bench.sv ***
// Self-checking bench for the program counter and data memory decoder.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module mmbd_decoder_bench;
    import mmbd_pkg::*;

    logic              ref_clk_i;
    logic              reset_i;
    logic              pc_step;
    logic              pc_load;
    logic              irq_accept;
    logic [10:0]       pc_target;
    mmbd_dreq_t        dreq;
    logic [PC_W-1:0]   pc_o;
    logic [PM_AW-1:0]  pm_addr_o;
    logic [7:0]        rdata_o;
    logic [DA_W-1:0]   dm_addr_o;
    logic              unimpl_o;
    logic [7:0]        status_o;
    logic [7:0]        pointer_o;
    logic [7:0]        intctl_o;
    logic              port_we_o;
    logic [7:0]        port_wdata_o;
    logic [7:0]        port_rdata;
    logic [7:0]        sm_rdata;
    logic              sm_unimpl;
    logic              sm_port_we;
    int                failures = 0;
    int                compares = 0;

    ////////////////////////////////////////////////////////////////////////
    mmbd_decoder i_mmbd_decoder (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .pc_step_i(pc_step),
        .pc_load_i(pc_load), .pc_target_i(pc_target),
        .irq_accept_i(irq_accept), .pc_o(pc_o), .pm_addr_o(pm_addr_o),
        .dreq_i(dreq), .rdata_o(rdata_o), .dm_addr_o(dm_addr_o),
        .unimpl_o(unimpl_o), .status_o(status_o), .pointer_o(pointer_o),
        .intctl_o(intctl_o), .port_we_o(port_we_o),
        .port_wdata_o(port_wdata_o), .port_rdata_i(port_rdata));

    // The small variant sees the same traffic; only its port decode differs.
    mmbd_decoder #(.HAS_PORTS_DE(1'b0)) i_mmbd_decoder_small (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .pc_step_i(pc_step),
        .pc_load_i(pc_load), .pc_target_i(pc_target),
        .irq_accept_i(irq_accept), .pc_o(), .pm_addr_o(), .dreq_i(dreq),
        .rdata_o(sm_rdata), .dm_addr_o(), .unimpl_o(sm_unimpl),
        .status_o(), .pointer_o(), .intctl_o(), .port_we_o(sm_port_we),
        .port_wdata_o(), .port_rdata_i(port_rdata));

    mmbd_port_model i_mmbd_port_model (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .we_i(port_we_o),
        .wdata_i(port_wdata_o), .rdata_o(port_rdata));

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    task automatic finish_test();
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic acc(input logic w, input logic r, input logic ind,
                       input logic [6:0] ofs, input logic [7:0] d);
        @(posedge ref_clk_i);
        dreq <= '{wr: w, rd: r, ind: ind, ofs: ofs, wdata: d};
        @(posedge ref_clk_i);
        dreq <= '0;
        #1;
    endtask

    task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
        acc(1'b1, 1'b0, 1'b0, ofs, d);
    endtask

    task automatic rd(input logic [6:0] ofs, input logic [7:0] e,
                      input string n);
        acc(1'b0, 1'b1, 1'b0, ofs, 8'h00);
        `CHK(n, e, rdata_o)
    endtask

    task automatic bank(input logic [1:0] b);
        wr(OFS_STATUS, {1'b0, b, 5'h00});
    endtask

    task automatic pc_op(input logic s, input logic l, input logic q,
                         input logic [10:0] t);
        @(posedge ref_clk_i);
        pc_step <= s;
        pc_load <= l;
        irq_accept <= q;
        pc_target <= t;
        @(posedge ref_clk_i);
        pc_step <= 1'b0;
        pc_load <= 1'b0;
        irq_accept <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset_i = 1'b1;
        pc_step = 1'b0;
        pc_load = 1'b0;
        irq_accept = 1'b0;
        pc_target = 11'h000;
        dreq = '0;
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        #1;
        `CHK("pc", 13'h0000, pc_o)
        `CHK("status", STATUS_RESET, status_o)
        repeat (3) pc_op(1'b1, 1'b0, 1'b0, 11'h000);
        `CHK("pc step", 13'h0003, pc_o)
        pc_op(1'b1, 1'b1, 1'b1, 11'h123);
        `CHK("pc irq", 13'h0004, pc_o)
        rd(OFS_PC_LOW, 8'h04, "pc low");
        wr(OFS_PCLATCH, 8'h08);
        rd(OFS_PCLATCH, 8'h08, "latch");
        pc_op(1'b0, 1'b1, 1'b0, 11'h7ff);
        `CHK("pc load", 13'h0fff, pc_o)
        `CHK("fetch", 11'h7ff, pm_addr_o)
        fork
            pc_op(1'b1, 1'b0, 1'b0, 11'h000);
            rd(OFS_POINTER, 8'h00, "data beside fetch");
        join
        `CHK("fetch wrap", 11'h000, pm_addr_o)
        `CHK("pc carry", 13'h1000, pc_o)
        for (int b = 0; b < 4; b++)
        begin
            bank(b[1:0]);
            `CHK("bank bits", b[1:0], status_o[6:5])
            rd(OFS_POINTER, 8'h00, "pointer mirror");
            `CHK("daddr", {b[1:0], OFS_POINTER}, dm_addr_o)
        end
        bank(2'd0);
        wr(7'h20, 8'ha5);
        wr(7'h7f, 8'h3c);
        wr(7'h60, 8'hc3);
        bank(2'd2);
        rd(7'h20, 8'ha5, "bank2 alias");
        bank(2'd1);
        rd(7'h7f, 8'h3c, "shared top");
        wr(7'h20, 8'h5e);
        wr(7'h40, 8'h99);
        rd(7'h40, 8'h00, "bank1 hole");
        `CHK("unimpl", 1'b1, unimpl_o)
        bank(2'd3);
        rd(7'h20, 8'h5e, "bank3 alias");
        wr(OFS_STATUS, 8'he0);
        wr(OFS_POINTER, 8'ha0);
        rd(OFS_INDIRECT, 8'h5e, "ind high");
        `CHK("ind high daddr", 9'h1a0, dm_addr_o)
        rd(7'h0e, 8'h00, "reserved");
        `CHK("reserved unimpl", 1'b1, unimpl_o)
        wr(OFS_POINTER, 8'h7f);
        wr(OFS_INTCTL, 8'h90);
        bank(2'd0);
        rd(7'h60, 8'hc3, "bank0 apart");
        rd(OFS_POINTER, 8'h7f, "pointer");
        rd(OFS_INTCTL, 8'h90, "intctl");
        `CHK("intctl out", 8'h90, intctl_o)
        wr(OFS_POINTER, 8'h25);
        wr(7'h25, 8'h5a);
        bank(2'd3);
        rd(OFS_INDIRECT, 8'h5a, "window");
        `CHK("ind daddr", 9'h025, dm_addr_o)
        acc(1'b1, 1'b0, 1'b1, 7'h33, 8'h66);
        bank(2'd0);
        rd(7'h25, 8'h66, "ind write");
        wr(OFS_PORT_FOUR, 8'h77);
        `CHK("port we", 1'b1, port_we_o)
        `CHK("port data", 8'h77, port_wdata_o)
        `CHK("small port we", 1'b0, sm_port_we)
        `CHK("small unimpl", 1'b1, sm_unimpl)
        rd(OFS_PORT_FOUR, 8'h77, "port read");
        `CHK("small port rd", 8'h00, sm_rdata)
        bank(2'd2);
        rd(OFS_PORT_FIVE, 8'h00, "port bank2");
        `CHK("port bank2 unimpl", 1'b1, unimpl_o)
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        `CHK("pc rereset", 13'h0000, pc_o)
        `CHK("status rereset", STATUS_RESET, status_o)
        `CHK("pointer rereset", 8'h00, pointer_o)
        @(posedge ref_clk_i);
        reset_i <= 1'b0;
        pc_op(1'b1, 1'b0, 1'b0, 11'h000);
        `CHK("pc after rereset", 13'h0001, pc_o)
        finish_test();
    end

    // The whole sequence takes some hundred and ten cycles.
    initial
    begin
        repeat (3000) @(posedge ref_clk_i);
        failures++;
        finish_test();
    end
endmodule // mmbd_decoder_bench
